// >>> adcsl_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - chain enable shifts chain input A into lane A
// - chain inputs B, C need enable and lane select
// - lane C driven only while its select is high
// - lane B driven only while its select is high
// - lane A driven while select high, else disabled
// - busy mode: status high for whole conversion
// - sequential mode: status rises at conversion start
// - sequential: one conversion clock low per pair
// - function bit set: status rises after completion
// - interrupt mode: first data read clears status
// - chain enable makes pin A a chain input, pins B and C only when their lane is selected
// - deselected lanes append their pair data onward
module adcsl_ctrl
	import adcsl_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	output logic                   irq,
	input  wire logic              sclk,
	input  wire logic              frame_sync_n,
	input  wire logic              conv_start,
	input  wire logic              chain_mode_enable,
	input  wire logic              chain_in_lane_a,
	input  wire logic              chain_in_lane_b,
	input  wire logic              chain_in_lane_c,
	input  wire logic              lane_sel_a,
	input  wire logic              lane_sel_b,
	input  wire logic              lane_sel_c,
	input  wire logic [RES_W-1:0]  adc_result,
	output logic                   serial_out_lane_a,
	output logic                   serial_out_lane_b,
	output logic                   serial_out_lane_c,
	output logic                   serial_out_lane_a_oe,
	output logic                   serial_out_lane_b_oe,
	output logic                   serial_out_lane_c_oe,
	output logic                   status_pin
);
	logic [SYNC_W-1:0]    pin_vec;
	logic [SYNC_W-1:0]    sync1_reg;
	logic [SYNC_W-1:0]    sync2_reg;
	logic [SYNC_W-1:0]    sync3_reg;
	logic                 sclk_rise;
	logic                 fs_fall;
	logic                 frame_on;
	logic                 start_rise;
	logic                 sel_b_s;
	logic                 sel_c_s;
	logic                 chain_s;
	logic [CTRL_W-1:0]    ctrl_reg;
	logic [IRQ_W-1:0]     irq_en_reg;
	logic [IRQ_W-1:0]     irq_stat_reg;
	logic [IRQ_W-1:0]     irq_set;
	logic [IRQ_W-1:0]     irq_clr;
	logic [DATA_W-1:0]    rdata_reg;
	logic                 irq_reg;
	adcsl_state_e         state_reg;
	adcsl_state_e         state_next;
	logic [CNT_W-1:0]     count_reg;
	logic [CNT_W-1:0]     count_next;
	logic [1:0]           pair_reg;
	logic [1:0]           pair_next;
	logic                 seq_run_reg;
	logic                 conv_done;
	logic                 pair_done;
	logic                 int_pend_reg;
	logic                 int_pend_next;
	logic                 status_reg;
	logic                 status_next;
	logic [RES_W-1:0]     result_reg;
	logic [NUM_LANES-1:0] oe_reg;
	logic [NUM_LANES-1:0] chain_en;
	logic                 func_bit;

	if (CCLK_CYCLES > PAIR_CYCLES || PAIR_CYCLES >= (1 << CNT_W))
	begin : g_bad_timing
		$error("conversion timing does not fit the counter");
	end

	// builds the bit stream of one lane, first bit in the top position
	function automatic logic [RES_W-1:0] lane_word(
		input logic [RES_W-1:0] r,
		input logic [1:0]       lane,
		input logic             sb,
		input logic             sc
	);
		logic [2*CH_W-1:0] pa;
		logic [2*CH_W-1:0] pb;
		logic [2*CH_W-1:0] pc;
		pa = r[RES_W-1 -: 2*CH_W];
		pb = r[4*CH_W-1 -: 2*CH_W];
		pc = r[2*CH_W-1:0];
		lane_word = '0;
		if (lane == 2'h0) begin
			if (!sb && !sc) begin
				lane_word = {pa, pb, pc};
			end else if (!sb) begin
				lane_word = {pa, pb, {(2*CH_W){1'b0}}};
			end else if (!sc) begin
				lane_word = {pa, pc[2*CH_W-1 -: CH_W], {(3*CH_W){1'b0}}};
			end else begin
				lane_word = {pa, {(4*CH_W){1'b0}}};
			end
		end else if (lane == 2'h1) begin
			if (!sc) begin
				lane_word = {pb, pc[CH_W-1:0], {(3*CH_W){1'b0}}};
			end else begin
				lane_word = {pb, {(4*CH_W){1'b0}}};
			end
		end else begin
			lane_word = {pc, {(4*CH_W){1'b0}}};
		end
	endfunction

	// pin synchroniser; third stage only serves edge detection
	assign pin_vec = {conv_start, frame_sync_n, sclk, chain_mode_enable,
	                  chain_in_lane_c, chain_in_lane_b, chain_in_lane_a,
	                  lane_sel_c, lane_sel_b, lane_sel_a};

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sync1_reg <= SYNC_RST;
			sync2_reg <= SYNC_RST;
			sync3_reg <= SYNC_RST;
		end else begin
			sync1_reg <= pin_vec;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	assign sclk_rise  = sync2_reg[IX_SCLK] & ~sync3_reg[IX_SCLK];
	assign fs_fall    = ~sync2_reg[IX_FS] & sync3_reg[IX_FS];
	assign frame_on   = ~sync2_reg[IX_FS];
	assign start_rise = sync2_reg[IX_CONV] & ~sync3_reg[IX_CONV];
	assign sel_b_s    = sync2_reg[IX_SEL_B];
	assign sel_c_s    = sync2_reg[IX_SEL_C];
	assign chain_s    = sync2_reg[IX_CHAIN_EN];
	assign func_bit   = ctrl_reg[CTRL_FUNC_BIT];

	// register writes
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ctrl_reg <= CTRL_RST;
		end else if (reg_wr && reg_addr == OFS_CTRL) begin
			ctrl_reg <= reg_wdata[CTRL_W-1:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			irq_en_reg <= IRQ_RST;
		end else if (reg_wr && reg_addr == OFS_IRQ_EN) begin
			irq_en_reg <= reg_wdata[IRQ_W-1:0];
		end
	end

	// sticky events, a new event beats a clear in the same cycle
	assign irq_set = {fs_fall, pair_done, conv_done};
	assign irq_clr = (reg_wr && reg_addr == OFS_IRQ_CLR) ?
	                 reg_wdata[IRQ_W-1:0] : IRQ_RST;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			irq_stat_reg <= IRQ_RST;
			irq_reg      <= 1'b0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
			irq_reg      <= |(irq_stat_reg & irq_en_reg);
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge mclk) begin
		if (sys_rst || !reg_rd) begin
			rdata_reg <= '0;
		end else begin
			unique case (reg_addr)
			OFS_CTRL: begin
				rdata_reg <= {{(DATA_W-CTRL_W){1'b0}}, ctrl_reg};
			end
			OFS_STATUS: begin
				rdata_reg <= {{(DATA_W-10){1'b0}}, sync2_reg[IX_CHAIN_EN],
				              sync2_reg[IX_SEL_C:IX_SEL_A], status_reg,
				              int_pend_reg, frame_on, pair_reg,
				              state_reg != ST_IDLE};
			end
			OFS_IRQ_STAT: begin
				rdata_reg <= {{(DATA_W-IRQ_W){1'b0}}, irq_stat_reg};
			end
			OFS_IRQ_EN: begin
				rdata_reg <= {{(DATA_W-IRQ_W){1'b0}}, irq_en_reg};
			end
			default: begin
				rdata_reg <= '0;
			end
			endcase
		end
	end

	// conversion sequencer
	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		pair_next  = pair_reg;
		conv_done  = 1'b0;
		pair_done  = 1'b0;
		unique case (state_reg)
		ST_IDLE: begin
			if (start_rise) begin
				state_next = ST_CONV;
				count_next = '0;
				pair_next  = '0;
			end
		end
		ST_CONV: begin
			if (count_reg == CNT_W'(PAIR_CYCLES - 1)) begin
				count_next = '0;
				pair_done  = seq_run_reg;
				if (!seq_run_reg || pair_reg == LAST_PAIR) begin
					state_next = ST_IDLE;
					conv_done  = 1'b1;
				end else begin
					state_next = ST_GAP;
					pair_next  = pair_reg + 2'h1;
				end
			end else begin
				count_next = count_reg + CNT_W'(1);
			end
		end
		ST_GAP: begin
			if (count_reg == CNT_W'(CCLK_CYCLES - 1)) begin
				state_next = ST_CONV;
				count_next = '0;
			end else begin
				count_next = count_reg + CNT_W'(1);
			end
		end
		default: begin
			state_next = ST_IDLE;
			count_next = '0;
			pair_next  = '0;
		end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
			count_reg <= '0;
			pair_reg  <= '0;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			pair_reg  <= pair_next;
		end
	end

	// mode is frozen for the length of one conversion
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			seq_run_reg <= 1'b0;
		end else if (state_reg == ST_IDLE && start_rise) begin
			seq_run_reg <= ctrl_reg[CTRL_SEQ_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			result_reg <= '0;
		end else if (conv_done) begin
			result_reg <= adc_result;
		end
	end

	// status pin: busy or interrupt; completion beats a read in one cycle
	assign int_pend_next = conv_done | (int_pend_reg & ~fs_fall);
	assign status_next   = func_bit ? int_pend_next :
	                       (state_next == ST_CONV);

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			int_pend_reg <= 1'b0;
			status_reg   <= 1'b0;
		end else begin
			int_pend_reg <= int_pend_next;
			status_reg   <= status_next;
		end
	end

	// lane drivers follow their select pins; lane A select held by host
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			oe_reg <= '0;
		end else begin
			oe_reg <= sync2_reg[IX_SEL_C:IX_SEL_A];
		end
	end

	assign chain_en[0] = chain_s;
	assign chain_en[1] = chain_s & sel_b_s;
	assign chain_en[2] = chain_s & sel_c_s;

	adcsl_lane_if #(.WORD_W(RES_W)) lane_bus [NUM_LANES] ();

	for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
		assign lane_bus[g].load     = fs_fall;
		assign lane_bus[g].shift    = sclk_rise & frame_on;
		assign lane_bus[g].chain_en = chain_en[g];
		assign lane_bus[g].chain_in = sync2_reg[IX_CIN_A + g];
		assign lane_bus[g].word     = lane_word(result_reg, 2'(g),
		                                        sel_b_s, sel_c_s);

		adcsl_lane #(
			.WORD_W (RES_W)
		) u_lane (
			.mclk    (mclk),
			.sys_rst (sys_rst),
			.bus     (lane_bus[g])
		);
	end

	assign reg_rdata            = rdata_reg;
	assign irq                  = irq_reg;
	assign serial_out_lane_a    = lane_bus[0].sout;
	assign serial_out_lane_b    = lane_bus[1].sout;
	assign serial_out_lane_c    = lane_bus[2].sout;
	assign serial_out_lane_a_oe = oe_reg[0];
	assign serial_out_lane_b_oe = oe_reg[1];
	assign serial_out_lane_c_oe = oe_reg[2];
	assign status_pin           = status_reg;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence seq_busy_begin;
		state_reg == ST_IDLE && start_rise && !func_bit &&
		!ctrl_reg[CTRL_SEQ_BIT];
	endsequence

	sequence seq_pair_end;
		state_reg == ST_CONV && seq_run_reg && !func_bit &&
		count_reg == CNT_W'(PAIR_CYCLES - 1) && pair_reg != LAST_PAIR;
	endsequence

	sequence seq_low_gap;
		!status_pin ##1 status_pin;
	endsequence

	a_chain_lane_a: assert property (
		lane_bus[0].chain_en == chain_s
	) else $error("lane A chain feed does not follow chain enable");

	a_chain_lane_bc: assert property (
		(lane_bus[1].chain_en || lane_bus[2].chain_en) |-> chain_s
	) else $error("lane B or C chain taken without chain enable");

	a_chain_sel_b: assert property (
		chain_s && !sel_b_s |-> !lane_bus[1].chain_en
	) else $error("lane B chain taken while lane B deselected");

	a_lane_c_oe: assert property (
		!sel_c_s |=> !serial_out_lane_c_oe
	) else $error("lane C driven while deselected");

	a_lane_b_oe: assert property (
		$rose(sel_b_s) |=> serial_out_lane_b_oe ##1 $stable(oe_reg[1])
		or ##1 !sel_b_s
	) else $error("lane B not driven after select");

	a_lane_a_oe: assert property (
		sync2_reg[IX_SEL_A] |=> serial_out_lane_a_oe
	) else $error("lane A not driven while selected");

	a_busy_whole: assert property (
		seq_busy_begin |=> status_pin [*8] ##1 status_pin [*8] ##1
		!status_pin
	) else $error("busy does not span the whole conversion");

	a_seq_rise: assert property (
		state_reg == ST_IDLE && start_rise && !func_bit &&
		ctrl_reg[CTRL_SEQ_BIT] |=> status_pin
	) else $error("sequential start does not raise busy");

	a_seq_gap: assert property (
		seq_pair_end |=> seq_low_gap
	) else $error("pair completion pulse is not one clock low");

	a_int_rise: assert property (
		func_bit && conv_done |=> status_pin
	) else $error("interrupt not raised after completion");

	a_int_clear: assert property (
		func_bit && fs_fall && !conv_done ##1 func_bit |-> !status_pin
	) else $error("interrupt not cleared by first read");

	a_append_c: assert property (
		lane_bus[1].load && !sel_c_s |->
		lane_bus[1].word[RES_W-2*CH_W-1 -: CH_W] == result_reg[CH_W-1:0]
	) else $error("pair C data not appended to lane B");

	a_single_lane: assert property (
		lane_bus[0].load && !sel_c_s && !sel_b_s |->
		lane_bus[0].word == result_reg
	) else $error("lane A does not carry all channels");

	a_busy_idle: assert property (
		!func_bit && state_reg == ST_IDLE && $past(state_reg) == ST_IDLE
		&& !$past(func_bit) |-> !status_pin
	) else $error("busy high with no conversion");
endmodule

// >>> adcsl_pkg.sv
package adcsl_pkg;
	// register port
	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 32;
	localparam logic [7:0]  OFS_CTRL     = 8'h00;
	localparam logic [7:0]  OFS_STATUS   = 8'h04;
	localparam logic [7:0]  OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0]  OFS_IRQ_CLR  = 8'h0c;
	localparam logic [7:0]  OFS_IRQ_EN   = 8'h10;
	// control word fields
	localparam int          CTRL_W       = 2;
	localparam int          CTRL_SEQ_BIT = 0;
	localparam int          CTRL_FUNC_BIT = 1;
	localparam logic [1:0]  CTRL_RST     = 2'h0;
	// event bits
	localparam int          IRQ_W        = 3;
	localparam int          IRQ_DONE_BIT = 0;
	localparam int          IRQ_PAIR_BIT = 1;
	localparam int          IRQ_FRAME_BIT = 2;
	localparam logic [2:0]  IRQ_RST      = 3'h0;
	// conversion data
	localparam int          CH_W         = 16;
	localparam int          RES_W        = 6 * CH_W;
	localparam logic [1:0]  LAST_PAIR    = 2'h2;
	localparam int          NUM_LANES    = 3;
	// timing
	localparam int          MCLK_NS      = 40;
	localparam int          CCLK_NS      = 40;
	localparam int          CCLK_CYCLES  = (CCLK_NS / MCLK_NS < 1) ? 1 :
	                                       CCLK_NS / MCLK_NS;
	localparam int          PAIR_CCLKS   = 16;
	localparam int          PAIR_CYCLES  = PAIR_CCLKS * CCLK_CYCLES;
	localparam int          CNT_W        = 8;
	// synchroniser bit positions
	localparam int          SYNC_W       = 10;
	localparam int          IX_SEL_A     = 0;
	localparam int          IX_SEL_B     = 1;
	localparam int          IX_SEL_C     = 2;
	localparam int          IX_CIN_A     = 3;
	localparam int          IX_CHAIN_EN  = 6;
	localparam int          IX_SCLK      = 7;
	localparam int          IX_FS        = 8;
	localparam int          IX_CONV      = 9;
	localparam logic [9:0]  SYNC_RST     = 10'h100;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CONV = 3'b010,
		ST_GAP  = 3'b100
	} adcsl_state_e;
endpackage

// >>> adcsl_lane_if.sv
`timescale 1ns/1ps
interface adcsl_lane_if
	import adcsl_pkg::*;
#(
	parameter int WORD_W = RES_W
) ();
	logic              load;
	logic              shift;
	logic              chain_en;
	logic              chain_in;
	logic [WORD_W-1:0] word;
	logic              sout;

	modport lane (
		input  load,
		input  shift,
		input  chain_en,
		input  chain_in,
		input  word,
		output sout
	);
	modport ctrl (
		output load,
		output shift,
		output chain_en,
		output chain_in,
		output word,
		input  sout
	);
endinterface

// >>> adcsl_lane.sv
`timescale 1ns/1ps
module adcsl_lane
	import adcsl_pkg::*;
#(
	parameter int WORD_W = RES_W
) (
	input wire logic   mclk,
	input wire logic   sys_rst,
	adcsl_lane_if.lane bus
);
	logic [WORD_W-1:0] shift_reg;

	if (WORD_W < 2 * CH_W) begin : g_bad_width
		$error("lane word must hold at least one channel pair");
	end

	// load wins over shift; chain bits enter behind the own data
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			shift_reg <= '0;
		end else if (bus.load) begin
			shift_reg <= bus.word;
		end else if (bus.shift) begin
			shift_reg <= {shift_reg[WORD_W-2:0],
			              bus.chain_en & bus.chain_in};
		end
	end

	assign bus.sout = shift_reg[WORD_W-1];
endmodule

// >>> adcsl_host_model.sv
`timescale 1ns/1ps
module adcsl_host_model #(
	parameter int HALF_NS = 160
) (
	output logic      sclk,
	output logic      frame_sync_n,
	output logic      conv_start,
	input  wire logic serial_out_lane_a,
	input  wire logic serial_out_lane_b,
	input  wire logic serial_out_lane_c
);
	initial begin
		sclk = 1'b0;
		frame_sync_n = 1'b1;
		conv_start = 1'b0;
	end

	// short pulse, still seen by the two sync flops
	task automatic start_conv();
		#13 conv_start = 1'b1;
		#60 conv_start = 1'b0;
	endtask

	// serial clock stands low outside frames; sample before each shift
	task automatic read_frame(output logic [103:0] a, b, c);
		a = '0;
		b = '0;
		c = '0;
		#7 frame_sync_n = 1'b0;
		#400;
		for (int i = 0; i < 104; i++) begin
			a = {a[102:0], serial_out_lane_a};
			b = {b[102:0], serial_out_lane_b};
			c = {c[102:0], serial_out_lane_c};
			sclk = 1'b1;
			#(HALF_NS) sclk = 1'b0;
			#(HALF_NS);
		end
		frame_sync_n = 1'b1;
		#200;
	endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top
	import adcsl_pkg::*;
;
	logic              mclk, sys_rst, reg_wr, reg_rd, irq, rd_d;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata;
	logic              sclk, frame_sync_n, conv_start, chain_mode_enable;
	logic              chain_in_lane_a, chain_in_lane_b, chain_in_lane_c;
	logic              lane_sel_a, lane_sel_b, lane_sel_c, status_pin;
	logic              serial_out_lane_a, serial_out_lane_b;
	logic              serial_out_lane_c, oe_a, oe_b, oe_c;
	logic [RES_W-1:0]  adc_result, r;
	logic [DATA_W-1:0] exp_q[$];
	logic [103:0]      fa, fb, fc;
	logic [51:0]       pat, pexp;
	int                num_errors, num_checks, cyc, n;
	integer            seed = 32'h7819549b;

	adcsl_ctrl i_adcsl_ctrl (.mclk(mclk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .sclk(sclk),
		.frame_sync_n(frame_sync_n), .conv_start(conv_start),
		.chain_mode_enable(chain_mode_enable),
		.chain_in_lane_a(chain_in_lane_a), .chain_in_lane_b(chain_in_lane_b),
		.chain_in_lane_c(chain_in_lane_c), .lane_sel_a(lane_sel_a),
		.lane_sel_b(lane_sel_b), .lane_sel_c(lane_sel_c),
		.adc_result(adc_result), .serial_out_lane_a(serial_out_lane_a),
		.serial_out_lane_b(serial_out_lane_b),
		.serial_out_lane_c(serial_out_lane_c),
		.serial_out_lane_a_oe(oe_a), .serial_out_lane_b_oe(oe_b),
		.serial_out_lane_c_oe(oe_c), .status_pin(status_pin));

	adcsl_host_model i_adcsl_host_model (.sclk(sclk),
		.frame_sync_n(frame_sync_n), .conv_start(conv_start),
		// a disabled lane reads as its grounded level
		.serial_out_lane_a(serial_out_lane_a & oe_a),
		.serial_out_lane_b(serial_out_lane_b & oe_b),
		.serial_out_lane_c(serial_out_lane_c & oe_c));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check_val(input logic [103:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic check_reg(input logic [DATA_W-1:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(posedge mclk);
	endtask

	// read data stand only in the cycle after the strobe
	always @(posedge mclk) begin
		rd_d <= reg_rd & ~sys_rst;
		if (rd_d)
			check_reg(reg_rdata, exp_q.pop_front());
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			stop_test();
		end
	end

	task automatic wait_pin(input logic v);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (status_pin !== v && n < 200);
		if (n >= 200)
			check_val(status_pin, v);
	endtask

	task automatic frame(input logic sb, sc, ce);
		lane_sel_b <= sb;
		lane_sel_c <= sc;
		chain_mode_enable <= ce;
		{chain_in_lane_a, chain_in_lane_b, chain_in_lane_c} <= 3'h7;
		r = {$random(seed), $random(seed), $random(seed)};
		adc_result <= r;
		repeat (6) @(posedge mclk);
		i_adcsl_host_model.start_conv();
		wait_pin(1'b1);
		wait_pin(1'b0);
		repeat (2) @(posedge mclk);
		i_adcsl_host_model.read_frame(fa, fb, fc);
	endtask

	initial begin
		sys_rst = 1'b1;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{chain_mode_enable, chain_in_lane_a} = 2'h0;
		{chain_in_lane_b, chain_in_lane_c} = 2'h0;
		{lane_sel_a, lane_sel_b, lane_sel_c} = 3'h7;
		adc_result = '0;
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge mclk);
		check_val(status_pin, 1'b0);
		reg_read(OFS_CTRL, 32'h0);
		reg_read(OFS_IRQ_STAT, 32'h0);
		reg_read(OFS_IRQ_EN, 32'h0);
		reg_read(8'h14, 32'h0);
		reg_read(8'h02, 32'h0);
		for (int s = 0; s < 8; s++) begin
			{lane_sel_c, lane_sel_b, lane_sel_a} <= s[2:0];
			repeat (6) @(posedge mclk);
			check_val({oe_c, oe_b, oe_a}, s[2:0]);
		end
		{lane_sel_c, lane_sel_b, lane_sel_a} <= 3'h7;
		reg_write(OFS_IRQ_EN, 32'h1);
		reg_read(OFS_STATUS, 32'h1c0);
		i_adcsl_host_model.start_conv();
		wait_pin(1'b1);
		n = 0;
		do begin
			n++;
			@(posedge mclk);
		end while (status_pin === 1'b1 && n < 100);
		check_val(n, PAIR_CYCLES);
		repeat (3) @(posedge mclk);
		check_val(irq, 1'b1);
		reg_read(OFS_IRQ_STAT, 32'h1);
		reg_write(OFS_IRQ_EN, 32'h0);
		repeat (2) @(posedge mclk);
		check_val(irq, 1'b0);
		reg_write(OFS_IRQ_EN, 32'h1);
		repeat (2) @(posedge mclk);
		check_val(irq, 1'b1);
		reg_write(OFS_IRQ_CLR, 32'h1);
		reg_read(OFS_IRQ_STAT, 32'h0);
		check_val(irq, 1'b0);
		reg_read(OFS_IRQ_CLR, 32'h0);
		reg_write(OFS_CTRL, 32'h1);
		reg_read(OFS_CTRL, 32'h1);
		i_adcsl_host_model.start_conv();
		wait_pin(1'b1);
		for (int i = 0; i < 52; i++) begin
			pat[i] = status_pin;
			pexp[i] = (i % (PAIR_CYCLES + 1)) != PAIR_CYCLES &&
				i < 3 * (PAIR_CYCLES + 1) - 1;
			@(posedge mclk);
		end
		check_val(pat, pexp);
		reg_write(OFS_CTRL, 32'h2);
		// earlier completions are still pending; read them out first
		i_adcsl_host_model.read_frame(fa, fb, fc);
		check_val(status_pin, 1'b0);
		i_adcsl_host_model.start_conv();
		repeat (10) @(posedge mclk);
		check_val(status_pin, 1'b0);
		wait_pin(1'b1);
		repeat (30) @(posedge mclk);
		check_val(status_pin, 1'b1);
		i_adcsl_host_model.read_frame(fa, fb, fc);
		check_val(status_pin, 1'b0);
		reg_write(OFS_CTRL, 32'h0);
		frame(1'b1, 1'b1, 1'b1);
		check_val(fa[103:72], r[95:64]);
		check_val(fb[103:72], r[63:32]);
		check_val(fc[103:72], r[31:0]);
		check_val({fa[7:0], fb[7:0], fc[7:0]}, 24'hffffff);
		frame(1'b1, 1'b0, 1'b1);
		check_val(fa[103:56], {r[95:64], r[31:16]});
		check_val(fb[103:56], {r[63:32], r[15:0]});
		check_val({fa[7:0], fb[7:0]}, 16'hffff);
		check_val(fc, 104'h0);
		frame(1'b0, 1'b0, 1'b1);
		check_val(fa[103:8], r);
		check_val(fb | fc, 104'h0);
		frame(1'b0, 1'b1, 1'b1);
		check_val(fa[103:40], r[95:32]);
		check_val(fc[103:72], r[31:0]);
		check_val({fb[7:0], fc[7:0]}, 16'h00ff);
		reg_write(OFS_IRQ_CLR, 32'h7);
		// chain inputs left high with chain mode off, on purpose
		frame(1'b1, 1'b1, 1'b0);
		check_val({fa[7:0], fb[7:0], fc[7:0]}, 24'h0);
		reg_read(OFS_IRQ_STAT, 32'h5);
		{chain_in_lane_a, chain_in_lane_b, chain_in_lane_c} <= 3'h0;
		repeat (4) @(posedge mclk);
		stop_test();
	end
endmodule
